// *** src/clk_startup_ctrl.sv ***
`timescale 1ns/1ps

module clk_startup_ctrl
  import clk_startup_pkg::*;
#(
  parameter int FAST_TO_TICKS = int'(TO_FAST_TICKS),
  parameter int SLOW_TO_TICKS = int'(TO_SLOW_TICKS),
  parameter int LFX_LONG_CNT  = LFX_LONG_CK
) (
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // Fuse array, static while running
  input  wire fuse_type          i_fuse,
  input  wire logic              i_fuse_blank,
  input  wire logic [7:0]        i_factory_cal,
  // Oscillator pins, asynchronous
  input  wire logic              i_src_clk,
  input  wire logic              i_wdt_osc,
  // Sleep controller
  input  wire logic              i_sleep_req,
  input  wire logic              i_wake_req,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [DATA_W-1:0]      o_rdata,
  // Clock system controls
  output logic                   o_core_rst,
  output logic                   o_clk_run,
  output logic                   o_rc_select,
  output logic [3:0]             o_clk_src_sel,
  output logic [3:0]             o_prescale_sel,
  output logic                   o_trim_range,
  output logic [6:0]             o_trim_step,
  output logic                   o_cfg_fault
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: every count must fit the counters
  if (FAST_TO_TICKS < 1 || FAST_TO_TICKS > 65535) begin : g_chk_fast
    $error("FAST_TO_TICKS out of range");
  end
  if (SLOW_TO_TICKS < 1 || SLOW_TO_TICKS > 65535) begin : g_chk_slow
    $error("SLOW_TO_TICKS out of range");
  end
  if (LFX_LONG_CNT < 1 || LFX_LONG_CNT > 65535) begin : g_chk_lfx
    $error("LFX_LONG_CNT out of range");
  end

  localparam logic [15:0] FAST_TO = 16'(FAST_TO_TICKS);
  localparam logic [15:0] SLOW_TO = 16'(SLOW_TO_TICKS);
  localparam logic [15:0] LFX_LONG = 16'(LFX_LONG_CNT);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a level counts once stages 2 and 3 agree
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] sync3_r;
  logic [1:0] flt_r;
  logic [1:0] flt_nxt;
  logic       src_edge;
  logic       wdt_edge;

  // Filtered level follows only a stable pair
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      flt_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : flt_r[i];
    end
  end

  // No reset here: the stages track the pins through reset, so a pin that is
  // already high at release is not mistaken for a fresh rising edge
  always_ff @(posedge i_mclk) begin
    sync1_r <= {i_wdt_osc, i_src_clk};
    sync2_r <= sync1_r;
    sync3_r <= sync2_r;
    flt_r   <= flt_nxt;
  end

  // Rising edges of the selected source and of the watchdog oscillator
  assign src_edge = flt_nxt[0] & ~flt_r[0];
  assign wdt_edge = flt_nxt[1] & ~flt_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  fuse_type fuse_r;
  fuse_type fuse_in;
  logic     is_rc;
  logic     is_ext;
  logic     is_lfx;
  logic     cfg_bad;

  // A blank fuse array reads as the shipped configuration
  assign fuse_in = i_fuse_blank ? FACTORY_FUSE : i_fuse;

  assign is_rc  = (fuse_r.clock_source_select == SRC_RC);
  assign is_ext = (fuse_r.clock_source_select == SRC_EXT);
  assign is_lfx = (fuse_r.clock_source_select[3:1] == SRC_LFX_HI);
  // Reserved startup code or a source this block does not serve
  assign cfg_bad = (fuse_r.startup_time_field == SUT_RSVD)
                 | ~(is_rc | is_ext | is_lfx);

  ////////////////////////////////////////////////////////////////////////////
  // Targets for the source-clock count and the watchdog time-out
  logic [15:0] wake_target;
  logic [15:0] to_target;

  // Wake-up length depends on the source only
  always_comb begin
    if (is_lfx) begin
      wake_target = fuse_r.clock_source_select[0] ? LFX_LONG : LFX_SHORT_CK;
    end else begin
      wake_target = WAKE_FAST_CK;
    end
  end

  // Reserved code falls back to no extra time-out rather than hanging
  always_comb begin
    case (fuse_r.startup_time_field)
      SUT_FAST: to_target = FAST_TO;
      SUT_SLOW: to_target = SLOW_TO;
      default:  to_target = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up sequencer
  phase_type   phase_r;
  phase_type   phase_nxt;
  logic [15:0] src_cnt_r;
  logic [15:0] src_cnt_nxt;
  logic [15:0] to_cnt_r;
  logic [15:0] to_cnt_nxt;
  logic        core_rst_r;
  logic        core_rst_nxt;
  logic        clk_run_r;
  logic        clk_run_nxt;
  logic        src_done;
  logic        to_done;

  assign src_done = (phase_r == PH_RESET) ? (src_cnt_r >= RESET_SRC_CK)
                                          : (src_cnt_r >= wake_target);
  assign to_done  = (to_cnt_r >= to_target);

  // Source clocks are counted, not used as a clock, so a stopped source just stalls
  always_comb begin
    phase_nxt    = phase_r;
    src_cnt_nxt  = src_cnt_r;
    to_cnt_nxt   = to_cnt_r;
    core_rst_nxt = core_rst_r;
    clk_run_nxt  = clk_run_r;
    case (phase_r)
      PH_RESET: begin
        if (src_edge && !src_done) begin
          src_cnt_nxt = src_cnt_r + 16'h0001;
        end
        if (wdt_edge && !to_done) begin
          to_cnt_nxt = to_cnt_r + 16'h0001;
        end
        if (src_done && to_done) begin
          phase_nxt    = PH_RUN;
          core_rst_nxt = 1'b0;
          clk_run_nxt  = 1'b1;
        end
      end
      PH_RUN: begin
        if (i_sleep_req) begin
          phase_nxt   = PH_SLEEP;
          clk_run_nxt = 1'b0;
        end
      end
      PH_SLEEP: begin
        // Supply is assumed good here, so only the start-up count applies
        if (i_wake_req) begin
          phase_nxt   = PH_WAKE;
          src_cnt_nxt = 16'h0000;
        end
      end
      PH_WAKE: begin
        if (src_done) begin
          phase_nxt   = PH_RUN;
          clk_run_nxt = 1'b1;
        end else if (src_edge) begin
          src_cnt_nxt = src_cnt_r + 16'h0001;
        end
      end
      default: begin
        phase_nxt    = PH_RESET;
        core_rst_nxt = 1'b1;
        clk_run_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      phase_r    <= PH_RESET;
      src_cnt_r  <= 16'h0000;
      to_cnt_r   <= 16'h0000;
      core_rst_r <= 1'b1;
      clk_run_r  <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      src_cnt_r  <= src_cnt_nxt;
      to_cnt_r   <= to_cnt_nxt;
      core_rst_r <= core_rst_nxt;
      clk_run_r  <= clk_run_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers: trim and prescale
  logic [7:0] trim_r;
  logic [7:0] trim_nxt;
  logic [3:0] presc_r;
  logic [3:0] presc_nxt;

  // Writes take effect at once; software must respect the memory-write limit
  always_comb begin
    trim_nxt  = trim_r;
    presc_nxt = presc_r;
    if (i_wr && i_addr == ADDR_TRIM) begin
      trim_nxt = i_wdata;
    end
    if (i_wr && i_addr == ADDR_PRESCALE) begin
      presc_nxt = i_wdata[3:0];
    end
  end

  // Fuses and calibration byte are caught on every reset cycle
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fuse_r  <= fuse_in;
      trim_r  <= i_factory_cal;
      presc_r <= fuse_in.divide_by_eight_fuse ? PRESCALE_DIV8 : PRESCALE_DIV1;
    end else begin
      fuse_r  <= fuse_r;
      trim_r  <= trim_nxt;
      presc_r <= presc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe
  logic [7:0] status;
  logic [1:0] phase_code;
  logic [7:0] rdata_nxt;

  always_comb begin
    case (phase_r)
      PH_RESET: phase_code = 2'h0;
      PH_RUN:   phase_code = 2'h1;
      PH_SLEEP: phase_code = 2'h2;
      PH_WAKE:  phase_code = 2'h3;
      default:  phase_code = 2'h0;
    endcase
  end

  // Status register gathers the block's own state
  always_comb begin
    status                    = 8'h00;
    status[ST_CORE_RST_BIT]   = core_rst_r;
    status[ST_RC_SEL_BIT]     = is_rc;
    status[ST_SUT_LSB +: 2]   = fuse_r.startup_time_field;
    status[ST_DIV8_BIT]       = fuse_r.divide_by_eight_fuse;
    status[ST_FAULT_BIT]      = cfg_bad;
    status[ST_PHASE_LSB +: 2] = phase_code;
  end

  // Unmapped address reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ADDR_TRIM:     rdata_nxt = trim_r;
        ADDR_PRESCALE: rdata_nxt = {4'h0, presc_r};
        ADDR_STATUS:   rdata_nxt = status;
        default:       rdata_nxt = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata        <= 8'h00;
      o_core_rst     <= 1'b1;
      o_clk_run      <= 1'b0;
      o_rc_select    <= 1'b0;
      o_clk_src_sel  <= 4'h0;
      o_prescale_sel <= 4'h0;
      o_trim_range   <= 1'b0;
      o_trim_step    <= 7'h00;
      o_cfg_fault    <= 1'b0;
    end else begin
      o_rdata        <= rdata_nxt;
      o_core_rst     <= core_rst_r;
      o_clk_run      <= clk_run_r;
      o_rc_select    <= is_rc;
      o_clk_src_sel  <= fuse_r.clock_source_select;
      o_prescale_sel <= presc_r;
      o_trim_range   <= trim_r[7];
      o_trim_step    <= trim_r[6:0];
      o_cfg_fault    <= cfg_bad;
    end
  end

endmodule

// *** src/clk_startup_pkg.sv ***
package clk_startup_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port and map
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 2;
  localparam logic [1:0]  ADDR_TRIM     = 2'h0;
  localparam logic [1:0]  ADDR_PRESCALE = 2'h1;
  localparam logic [1:0]  ADDR_STATUS   = 2'h2;

  // Status register field positions
  localparam int ST_CORE_RST_BIT = 0;
  localparam int ST_RC_SEL_BIT   = 1;
  localparam int ST_SUT_LSB      = 2;
  localparam int ST_DIV8_BIT     = 4;
  localparam int ST_FAULT_BIT    = 5;
  localparam int ST_PHASE_LSB    = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Clock source select codes
  localparam logic [3:0] SRC_EXT     = 4'h0;
  localparam logic [3:0] SRC_RC      = 4'h2;
  localparam logic [2:0] SRC_LFX_HI  = 3'h2;  // Bits 3..1; bit 0 picks start length

  // Startup-time field codes
  localparam logic [1:0] SUT_NONE = 2'h0;
  localparam logic [1:0] SUT_FAST = 2'h1;
  localparam logic [1:0] SUT_SLOW = 2'h2;
  localparam logic [1:0] SUT_RSVD = 2'h3;

  // Prescale select values after reset
  localparam logic [3:0] PRESCALE_DIV1 = 4'h0;
  localparam logic [3:0] PRESCALE_DIV8 = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Source-clock counts
  localparam int          CNT_W        = 16;
  localparam logic [15:0] RESET_SRC_CK = 16'h000E;  // 14 CK
  localparam logic [15:0] WAKE_FAST_CK = 16'h0006;  // 6 CK
  localparam logic [15:0] LFX_SHORT_CK = 16'h0400;  // 1K CK
  localparam int          LFX_LONG_CK  = 32768;     // 32K CK

  // Millisecond time-outs, timed by the watchdog oscillator
  localparam longint TO_FAST_US    = 4100;   // 4.1 ms
  localparam longint TO_SLOW_US    = 65000;  // 65 ms
  localparam longint WDT_OSC_HZ    = 128000;
  localparam longint TO_FAST_TICKS = (TO_FAST_US * WDT_OSC_HZ + 999999) / 1000000;
  localparam longint TO_SLOW_TICKS = (TO_SLOW_US * WDT_OSC_HZ + 999999) / 1000000;

  ////////////////////////////////////////////////////////////////////////////
  // Fuse bundle and factory default
  typedef struct packed {
    logic [3:0] clock_source_select;
    logic [1:0] startup_time_field;
    logic       divide_by_eight_fuse;
  } fuse_type;

  localparam fuse_type FACTORY_FUSE = '{
    clock_source_select  : SRC_RC,
    startup_time_field   : SUT_SLOW,
    divide_by_eight_fuse : 1'b1
  };

  // Start-up phases
  typedef enum logic [1:0] {
    PH_RESET,
    PH_RUN,
    PH_SLEEP,
    PH_WAKE
  } phase_type;

endpackage

// *** tb/clk_startup_checker.sv ***
`timescale 1ns/1ps

module clk_startup_checker
  import clk_startup_pkg::*;
#(
  parameter int FAST_TO_TICKS = 5,
  parameter int SLOW_TO_TICKS = 9,
  parameter int LFX_LONG_CNT  = 40
) (
  // Watched ports
  input wire logic              i_mclk,
  input wire logic              i_rst,
  input wire fuse_type          i_fuse,
  input wire logic              i_fuse_blank,
  input wire logic [7:0]        i_factory_cal,
  input wire logic              i_src_clk,
  input wire logic              i_wdt_osc,
  input wire logic              i_sleep_req,
  input wire logic              i_wake_req,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_core_rst,
  input wire logic              o_clk_run,
  input wire logic              o_rc_select,
  input wire logic [3:0]        o_clk_src_sel,
  input wire logic [3:0]        o_prescale_sel,
  input wire logic              o_trim_range,
  input wire logic [6:0]        o_trim_step,
  input wire logic              o_cfg_fault
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin edges delayed by the three clocks that the design's pin path takes
  logic [3:0]  src_d;
  logic [3:0]  wdt_d;
  logic        src_rise;
  logic        wdt_rise;
  logic        woken;
  logic [15:0] src_cnt;
  logic [15:0] wdt_cnt;
  logic [15:0] wk_cnt;
  logic [1:0]  sut;
  int          to_tgt;
  int          wk_tgt;

  assign sut    = i_fuse_blank ? SUT_SLOW : i_fuse.startup_time_field;
  assign to_tgt = (sut == SUT_FAST) ? FAST_TO_TICKS : (sut == SUT_SLOW) ? SLOW_TO_TICKS : 0;
  assign wk_tgt = (o_clk_src_sel[3:1] != SRC_LFX_HI) ? 6 :
                  o_clk_src_sel[0] ? LFX_LONG_CNT : 1024;

  // A rise counts at the edge where the design's pin path delivers it
  assign src_rise = src_d[2] && !src_d[3];
  assign wdt_rise = wdt_d[2] && !wdt_d[3];

  // Edge counters, cleared by reset; wake count restarts at each wake request made while the clock is stopped out of reset
  always_ff @(posedge i_mclk) begin
    src_d <= {src_d[2:0], i_src_clk};
    wdt_d <= {wdt_d[2:0], i_wdt_osc};
    if (i_rst) begin
      src_cnt <= 16'h0000;
      wdt_cnt <= 16'h0000;
      wk_cnt  <= 16'h0000;
      woken   <= 1'b0;
    end else begin
      if (src_rise) src_cnt <= src_cnt + 16'h0001;
      if (wdt_rise) wdt_cnt <= wdt_cnt + 16'h0001;
      if (i_sleep_req) woken <= 1'b0;
      if (i_wake_req && !o_clk_run && !o_core_rst) begin
        woken  <= 1'b1;
        wk_cnt <= 16'h0000;
      end else if (src_rise) begin
        wk_cnt <= wk_cnt + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence left_reset_s;
    $fell(i_rst);
  endsequence

  sequence trim_wr_s;
    i_wr && (i_addr == ADDR_TRIM);
  endsequence

  rc_map_a: assert property (
    o_rc_select == (o_clk_src_sel == SRC_RC)) else $error("rc select disagrees with source");
  trim_load_a: assert property (
    left_reset_s |-> ##[1:2] {o_trim_range, o_trim_step} == i_factory_cal)
    else $error("trim not loaded from calibration byte");
  prescale_rst_a: assert property (
    left_reset_s |-> ##[1:2] o_prescale_sel ==
      ((i_fuse_blank || i_fuse.divide_by_eight_fuse) ? PRESCALE_DIV8 : PRESCALE_DIV1))
    else $error("prescale reset value wrong");
  factory_cfg_a: assert property (
    (left_reset_s and i_fuse_blank) |-> ##[1:2] o_rc_select && (o_clk_src_sel == SRC_RC))
    else $error("blank fuses did not select rc oscillator");
  hold_src_a: assert property (
    $fell(o_core_rst) |-> src_cnt >= 16'h000E) else $error("released before 14 clocks");
  hold_wdt_a: assert property (
    $fell(o_core_rst) |-> wdt_cnt >= to_tgt) else $error("released before time-out");
  release_a: assert property (
    o_core_rst && src_cnt >= 16'h000F && wdt_cnt >= to_tgt + 1 |-> ##[0:8] !o_core_rst)
    else $error("reset held after both counts expired");
  wake_min_a: assert property (
    woken && $rose(o_clk_run) |-> wk_cnt + 16'h0001 >= wk_tgt) else $error("woke too early");
  wake_max_a: assert property (
    woken && !o_clk_run && wk_cnt >= wk_tgt + 1 |-> ##[0:8] o_clk_run)
    else $error("woke too late");
  trim_write_a: assert property (
    trim_wr_s |-> ##2 {o_trim_range, o_trim_step} == $past(i_wdata, 2))
    else $error("trim write not applied");
endmodule

// *** tb/osc_model.sv ***
`timescale 1ns/1ps

// Oscillator pin at a fixed rate; held low while disabled so no stale edge leaks out
module osc_model #(
  parameter real HALF_NS = 30.0
) (
  input  wire logic i_en,
  output logic      o_clk
);
  // Constant half period, so there is never a step in frequency between cycles
  initial begin
    o_clk = 1'b0;
    // Half-nanosecond offset keeps pin edges off the system clock edges
    #(0.5);
    forever begin
      #(HALF_NS);
      o_clk = i_en ? ~o_clk : 1'b0;
    end
  end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps

module testbench
  import clk_startup_pkg::*;
;
  localparam int FAST = 5;
  localparam int SLOW = 9;
  localparam int LFX  = 40;

  typedef struct packed {
    fuse_type    fuse;
    logic        blank;
    logic [7:0]  cal;
    logic [3:0]  pre;
    logic        rc;
    logic [15:0] wake;
  } row_type;

  logic i_mclk, i_rst, i_fuse_blank, i_src_clk, i_wdt_osc, i_sleep_req, i_wake_req;
  logic i_wr, i_rd, o_core_rst, o_clk_run, o_rc_select, o_trim_range, o_cfg_fault, src_on;
  fuse_type          i_fuse;
  logic [7:0]        i_factory_cal;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic [DATA_W-1:0] o_rdata;
  logic [3:0]        o_clk_src_sel;
  logic [3:0]        o_prescale_sel;
  logic [6:0]        o_trim_step;
  logic [3:0]        src_exp;
  int                bad_count;
  int                checks_done;
  int                src_edges;
  row_type           rows [5] = '{
    '{'{SRC_EXT, SUT_NONE, 1'b0}, 1'b1, 8'h5A, PRESCALE_DIV8, 1'b1, 16'h0006},
    '{'{SRC_RC, SUT_NONE, 1'b0}, 1'b0, 8'hA5, PRESCALE_DIV1, 1'b1, 16'h0006},
    '{'{SRC_EXT, SUT_FAST, 1'b1}, 1'b0, 8'h7F, PRESCALE_DIV8, 1'b0, 16'h0006},
    '{'{4'h4, SUT_SLOW, 1'b0}, 1'b0, 8'h80, PRESCALE_DIV1, 1'b0, 16'h0400},
    '{'{4'h5, SUT_NONE, 1'b1}, 1'b0, 8'h3C, PRESCALE_DIV8, 1'b0, 16'(LFX)}};

  clk_startup_ctrl #(.FAST_TO_TICKS(FAST), .SLOW_TO_TICKS(SLOW), .LFX_LONG_CNT(LFX)) i_dut (.*);
  osc_model #(.HALF_NS(33.0)) i_src (.i_en(src_on), .o_clk(i_src_clk));
  osc_model #(.HALF_NS(47.0)) i_wdt (.i_en(1'b1), .o_clk(i_wdt_osc));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, raw source edge count, and a watchdog well past the expected run
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  always @(posedge i_src_clk) src_edges++;
  initial begin
    #400us;
    bad_count++;
    finish_test();
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus tasks start just after a rising edge and end on one
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
    i_rd <= 1'b1;
    i_wr <= 1'b0;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    chk(what, 16'(exp), 16'(o_rdata));
    @(posedge i_mclk);
  endtask

  task automatic wait_rel;
    for (int n = 0; n < 3000 && o_core_rst !== 1'b0; n++) @(posedge i_mclk);
  endtask

  // Fuses and calibration stay fixed through the reset that catches them
  task automatic start(input fuse_type f, input logic b, input logic [7:0] c);
    i_fuse <= f;
    i_fuse_blank <= b;
    i_factory_cal <= c;
    i_rst <= 1'b1;
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    repeat (6) @(posedge i_mclk);
    i_rst <= 1'b0;
    wait_rel();
  endtask

  task automatic nap(input logic [15:0] tgt);
    int e0;
    int seen;
    i_sleep_req <= 1'b1;
    @(posedge i_mclk);
    i_sleep_req <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk("clock run in sleep", 16'h0000, 16'(o_clk_run));
    e0 = src_edges;
    i_wake_req <= 1'b1;
    @(posedge i_mclk);
    i_wake_req <= 1'b0;
    for (int n = 0; n < 20000 && o_clk_run !== 1'b1; n++) @(posedge i_mclk);
    seen = src_edges - e0;
    chk("wake edge count", tgt, (seen + 1 >= tgt && seen <= tgt + 1) ? tgt : 16'(seen));
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst, src_on} = 2'b11;
    {i_fuse, i_fuse_blank, i_factory_cal, i_sleep_req, i_wake_req} = '0;
    {i_addr, i_wdata, i_wr, i_rd} = '0;
    for (int r = 0; r < 5; r++) begin
      start(rows[r].fuse, rows[r].blank, rows[r].cal);
      chk("core reset", 16'h0000, 16'(o_core_rst));
      rd(ADDR_TRIM, rows[r].cal, "trim");
      rd(ADDR_PRESCALE, {4'h0, rows[r].pre}, "prescale");
      chk("rc select", 16'(rows[r].rc), 16'(o_rc_select));
      src_exp = rows[r].blank ? SRC_RC : rows[r].fuse.clock_source_select;
      chk("source select", 16'(src_exp), 16'(o_clk_src_sel));
      chk("config fault", 16'h0000, 16'(o_cfg_fault));
      nap(rows[r].wake);
      $display("test row %0d done", r);
    end
    // Back-to-back trim writes across the overlapping range boundary
    wr(ADDR_TRIM, 8'h7F);
    wr(ADDR_TRIM, 8'h80);
    wr(ADDR_PRESCALE, 8'hF7);
    wr(2'h3, 8'hFF);
    rd(ADDR_TRIM, 8'h80, "trim");
    chk("trim range", 16'h0001, 16'(o_trim_range));
    chk("trim step", 16'h0000, 16'(o_trim_step));
    rd(ADDR_PRESCALE, 8'h07, "prescale");
    rd(2'h3, 8'h00, "unmapped");
    $display("test trim writes done");
    // Reserved startup code; the new reset reloads trim over the written value
    start('{SRC_RC, SUT_RSVD, 1'b0}, 1'b0, 8'h11);
    chk("config fault", 16'h0001, 16'(o_cfg_fault));
    rd(ADDR_STATUS, 8'h6E, "status");
    rd(ADDR_TRIM, 8'h11, "trim");
    $display("test reserved code done");
    // A silent source must keep the core in reset however long it takes
    src_on = 1'b0;
    start('{SRC_EXT, SUT_NONE, 1'b0}, 1'b0, 8'h22);
    chk("core reset held", 16'h0001, 16'(o_core_rst));
    src_on = 1'b1;
    wait_rel();
    chk("core reset", 16'h0000, 16'(o_core_rst));
    $display("test stopped source done");
    finish_test();
  end
endmodule

bind clk_startup_ctrl clk_startup_checker #(
  .FAST_TO_TICKS(FAST_TO_TICKS),
  .SLOW_TO_TICKS(SLOW_TO_TICKS),
  .LFX_LONG_CNT(LFX_LONG_CNT)
) i_chk (.*);
